// ===== core/checkback_pkg.sv
// Constants, register map and carrier types of the checkback test scheduler.
// Assumes a 50 MHz system clock; all schedule timing counts whole seconds.
package checkback_pkg;

  // Clock and one-second tick
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1_000_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Time figures
  localparam logic [19:0] SEC_PER_HOUR = 20'h00e10;
  localparam logic [19:0] SEC_PER_MIN = 20'h0003c;
  localparam logic [5:0] MASTER_TIMED_MIN = 6'h05;
  localparam logic [5:0] GRACE_STEP_MIN = 6'h05;
  localparam logic [4:0] SYNC_HOUR = 5'h00;
  localparam logic [5:0] SYNC_MIN = 6'h1e;
  localparam logic [1:0] RECOVERY_PASSES = 2'h3;
  localparam logic [2:0] RECOVER_OUT_S = 3'h5;

  // Setting ranges
  localparam logic [6:0] PERIOD_MIN_H = 7'h01;
  localparam logic [6:0] PERIOD_MAX_H = 7'h78;
  localparam logic [5:0] REC_MIN_MIN = 6'h05;
  localparam logic [5:0] REC_MAX_MIN = 6'h3c;
  localparam logic [4:0] WINDOW_MIN_H = 5'h01;
  localparam logic [4:0] WINDOW_MAX_H = 5'h18;
  localparam logic [4:0] HOUR_MAX = 5'h17;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMES = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_SETUP = 8'h0c;
  localparam logic [7:0] OFS_TOD = 8'h10;
  localparam logic [7:0] OFS_DATE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // CTRL bits
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_PERIODIC = 1;
  localparam int CTRL_RECOVERY = 2;
  localparam int CTRL_SYNC = 3;
  localparam int CTRL_CODED = 4;
  localparam int CTRL_FALLBACK = 5;
  localparam int CTRL_TEST = 8;

  // Reset values
  localparam logic [6:0] PERIOD_RST = 7'h08;
  localparam logic [5:0] REC_RST = 6'h0f;
  localparam logic [4:0] WINDOW_RST = 5'h01;
  localparam logic [3:0] RETRIES_RST = 4'h3;

  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } tod_t;

  typedef struct packed {
    logic [15:0] year;
    logic [3:0] month;
    logic [4:0] day;
  } date_t;

  typedef enum logic [2:0] {
    OUT_DELAY = 3'b000,
    OUT_TESTING = 3'b001,
    OUT_PASS = 3'b010,
    OUT_RECOVER = 3'b011,
    OUT_DISABLE = 3'b100
  } out_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAUNCH = 2'b01,
    ST_WAIT = 2'b10
  } test_state_t;

endpackage

// ===== core/checkback_test_scheduler.sv
// Checkback test scheduler: test sources, retries, recovery, clock and sync.
// Assumes an external test engine answering each test_start with test_done.
`timescale 1ns/1ps

module checkback_test_scheduler
  import checkback_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Front panel and rear contact
  input wire logic test_pushbutton,
  input wire logic rear_test_contact,
  input wire logic config_custom,
  // Test engine
  output logic test_start,
  output logic test_low_power,
  output logic test_timed_mode,
  input wire logic test_done,
  input wire logic test_pass,
  input wire logic message_busy,
  // Traffic from peer modules
  input wire logic peer_test_good,
  input wire logic sync_load,
  input wire tod_t sync_time_in,
  output logic sync_push,
  output tod_t sync_time_out,
  // Indicators and outputs
  output logic recovery_led,
  output logic major_alarm,
  output logic delayed_alarm,
  output logic [2:0] user_out
);

  logic auto_en, periodic_mode, recovery_en, sync_en, primary_coded, fallback_en;
  logic [4:0] test_hour [4];
  logic [6:0] period_h;
  logic [5:0] rec_min;
  logic [4:0] window_h;
  logic [3:0] address;
  logic [3:0] retries;
  out_sel_t out_sel [3];
  tod_t tod;
  date_t date;
  logic [31:0] tick_cnt;
  logic tick, tick_d;
  logic btn_q, rear_q, cmd_test, manual_req, auto_req, req_pending;
  logic timed_hit, per_fire, rec_fire, heard;
  logic [19:0] per_cnt, rec_cnt, win_cnt;
  test_state_t state;
  logic [3:0] attempts;
  logic fallback_phase, fallback_go, out_good, out_fail;
  logic recovery_mode, recovered, pass_flag, blink;
  logic [1:0] pass_cnt;
  logic [2:0] rcv_hold;
  logic is_master, wr, rd_setup;
  logic [31:0] next_rdata;

  function automatic logic [19:0] hours_to_sec(input logic [6:0] h);
    return 20'(h) * SEC_PER_HOUR;
  endfunction

  function automatic logic [19:0] min_to_sec(input logic [5:0] m);
    return 20'(m) * SEC_PER_MIN;
  endfunction

  function automatic logic at_time(input tod_t t, input logic [4:0] h, input logic [5:0] m);
    return t.hour == h && t.minute == m && t.second == 6'h00;
  endfunction

  assign is_master = address == 4'h0;
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;

  // APB read data, captured in the setup phase
  always_comb
  begin
    next_rdata = 32'h00000000;
    case (paddr)
      OFS_CTRL: next_rdata = {26'h0000000, fallback_en, primary_coded, sync_en,
                              recovery_en, periodic_mode, auto_en};
      OFS_TIMES: next_rdata = {3'h0, test_hour[3], 3'h0, test_hour[2],
                               3'h0, test_hour[1], 3'h0, test_hour[0]};
      OFS_PERIOD: next_rdata = {11'h000, window_h, 2'h0, rec_min, 1'b0, period_h};
      OFS_SETUP: next_rdata = {5'h00, out_sel[2], 1'b0, out_sel[1], 1'b0, out_sel[0],
                               4'h0, retries, 4'h0, address};
      OFS_TOD: next_rdata = {11'h000, tod.hour, 2'h0, tod.minute, 2'h0, tod.second};
      OFS_DATE: next_rdata = {date.year, 4'h0, date.month, 3'h0, date.day};
      OFS_STATUS: next_rdata = {23'h000000, config_custom, fallback_phase, pass_cnt,
                                state != ST_IDLE, major_alarm, delayed_alarm,
                                recovered, recovery_mode};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h00000000;
    else if (rd_setup)
      prdata <= next_rdata;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pslverr <= 1'b0;
    else if (psel && !penable)
      pslverr <= paddr > OFS_STATUS || paddr[1:0] != 2'h0;
  end

  // Configuration registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      auto_en <= 1'b0;
      periodic_mode <= 1'b0;
      recovery_en <= 1'b0;
      sync_en <= 1'b0;
      primary_coded <= 1'b0;
      fallback_en <= 1'b0;
      test_hour <= '{default: 5'h00};
      period_h <= PERIOD_RST;
      rec_min <= REC_RST;
      window_h <= WINDOW_RST;
      address <= 4'h0;
      retries <= RETRIES_RST;
      out_sel <= '{default: OUT_DELAY};
    end
    else if (wr && !pslverr)
    begin
      case (paddr)
        OFS_CTRL:
        begin
          if (config_custom)
          begin
            auto_en <= pwdata[CTRL_AUTO];
            periodic_mode <= pwdata[CTRL_PERIODIC];
          end
          recovery_en <= pwdata[CTRL_RECOVERY];
          sync_en <= pwdata[CTRL_SYNC];
          primary_coded <= pwdata[CTRL_CODED];
          fallback_en <= pwdata[CTRL_FALLBACK];
        end
        OFS_TIMES:
        begin
          for (int i = 0; i < 4; i++)
          begin
            if (config_custom && pwdata[8*i +: 5] <= HOUR_MAX)
              test_hour[i] <= pwdata[8*i +: 5];
          end
        end
        OFS_PERIOD:
        begin
          if (config_custom && pwdata[6:0] >= PERIOD_MIN_H && pwdata[6:0] <= PERIOD_MAX_H)
            period_h <= pwdata[6:0];
          if (pwdata[13:8] >= REC_MIN_MIN && pwdata[13:8] <= REC_MAX_MIN)
            rec_min <= pwdata[13:8];
          if (pwdata[20:16] >= WINDOW_MIN_H && pwdata[20:16] <= WINDOW_MAX_H)
            window_h <= pwdata[20:16];
        end
        OFS_SETUP:
        begin
          address <= pwdata[3:0];
          retries <= pwdata[11:8];
          for (int i = 0; i < 3; i++)
          begin
            if (pwdata[16 + 4*i +: 3] <= OUT_DISABLE)
              out_sel[i] <= out_sel_t'(pwdata[16 + 4*i +: 3]);
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // One-second tick
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b0;
      tick_d <= 1'b0;
    end
    else
    begin
      tick <= tick_cnt == 32'(TICK_COUNT - 1);
      tick_cnt <= (tick_cnt == 32'(TICK_COUNT - 1)) ? 32'h00000000 : tick_cnt + 32'h1;
      tick_d <= tick;
    end
  end

  // Time of day and date
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tod <= '0;
      date <= '0;
    end
    else if (wr && paddr == OFS_TOD)
      tod <= '{hour: pwdata[20:16], minute: pwdata[13:8], second: pwdata[5:0]};
    else if (wr && paddr == OFS_DATE)
      date <= '{year: pwdata[31:16], month: pwdata[11:8], day: pwdata[4:0]};
    else if (sync_load && !is_master)
      tod <= sync_time_in;
    else if (tick)
    begin
      if (tod.second != 6'h3b)
        tod.second <= tod.second + 6'h01;
      else
      begin
        tod.second <= 6'h00;
        if (tod.minute != 6'h3b)
          tod.minute <= tod.minute + 6'h01;
        else
        begin
          tod.minute <= 6'h00;
          tod.hour <= (tod.hour == HOUR_MAX) ? 5'h00 : tod.hour + 5'h01;
        end
      end
    end
  end

  // Daily clock push from the master
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_push <= 1'b0;
      sync_time_out <= '0;
    end
    else
    begin
      sync_push <= sync_en && is_master && tick_d && at_time(tod, SYNC_HOUR, SYNC_MIN);
      if (tick_d)
        sync_time_out <= tod;
    end
  end

  // Manual sources
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      btn_q <= 1'b0;
      rear_q <= 1'b0;
      cmd_test <= 1'b0;
    end
    else
    begin
      btn_q <= test_pushbutton;
      rear_q <= rear_test_contact;
      cmd_test <= wr && paddr == OFS_CTRL && pwdata[CTRL_TEST];
    end
  end

  assign manual_req = (btn_q && !test_pushbutton) || (rear_test_contact && !rear_q)
                      || cmd_test;

  // Timed schedule: master at hh:05, remote n at hh:05+5n unless heard
  always_comb
  begin
    timed_hit = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (at_time(tod, test_hour[i], MASTER_TIMED_MIN + 6'(GRACE_STEP_MIN * address)))
        timed_hit = 1'b1;
    end
    timed_hit = timed_hit && tick_d && auto_en && !periodic_mode && !recovery_mode
                && !(is_master && message_busy) && !(!is_master && heard);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      heard <= 1'b0;
    else if (peer_test_good)
      heard <= 1'b1;
    else if (tick_d && tod.minute == 6'h00 && tod.second == 6'h00)
      heard <= 1'b0;
  end

  // Periodic timer, running from reset; remotes add their grace
  assign per_fire = tick && auto_en && periodic_mode && !recovery_mode
                    && per_cnt + 20'h1 >= hours_to_sec(period_h)
                       + 20'(address) * min_to_sec(GRACE_STEP_MIN);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      per_cnt <= 20'h00000;
    else if (out_good || peer_test_good || per_fire)
      per_cnt <= 20'h00000;
    else if (tick)
      per_cnt <= per_cnt + 20'h1;
  end

  // Recovery period and window timers
  assign rec_fire = tick && recovery_mode && rec_cnt + 20'h1 >= min_to_sec(rec_min);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rec_cnt <= 20'h00000;
      win_cnt <= 20'h00000;
      delayed_alarm <= 1'b0;
    end
    else if (!recovery_mode)
    begin
      rec_cnt <= 20'h00000;
      win_cnt <= 20'h00000;
      delayed_alarm <= 1'b0;
    end
    else if (tick)
    begin
      rec_cnt <= rec_fire ? 20'h00000 : rec_cnt + 20'h1;
      if (win_cnt + 20'h1 >= hours_to_sec(7'(window_h)))
        delayed_alarm <= 1'b1;
      else
        win_cnt <= win_cnt + 20'h1;
    end
  end

  // Pending test request
  assign auto_req = timed_hit || per_fire || rec_fire;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      req_pending <= 1'b0;
    else if (manual_req || auto_req)
      req_pending <= 1'b1;
    else if (state == ST_LAUNCH && !fallback_phase && attempts == 4'h0)
      req_pending <= 1'b0;
  end

  // Test sequencing with retries and timed fallback
  assign test_start = state == ST_LAUNCH;
  // Last try switches to timed mode, visible with its start pulse
  assign fallback_go = state == ST_WAIT && test_done && !test_pass && !fallback_phase
                       && attempts >= retries && primary_coded && fallback_en;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      attempts <= 4'h0;
      fallback_phase <= 1'b0;
      out_good <= 1'b0;
      out_fail <= 1'b0;
    end
    else
    begin
      out_good <= 1'b0;
      out_fail <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          attempts <= 4'h0;
          fallback_phase <= 1'b0;
          if (req_pending && !message_busy)
            state <= ST_LAUNCH;
        end
        ST_LAUNCH:
          state <= ST_WAIT;
        ST_WAIT:
        begin
          if (test_done && test_pass)
          begin
            out_good <= 1'b1;
            state <= ST_IDLE;
          end
          else if (test_done && !fallback_phase && attempts < retries)
          begin
            attempts <= attempts + 4'h1;
            state <= ST_LAUNCH;
          end
          else if (test_done && !fallback_phase && primary_coded && fallback_en)
          begin
            fallback_phase <= 1'b1;
            state <= ST_LAUNCH;
          end
          else if (test_done)
          begin
            out_fail <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      test_timed_mode <= 1'b0;
      test_low_power <= 1'b0;
    end
    else
    begin
      test_timed_mode <= ((fallback_phase && state != ST_IDLE) || fallback_go)
                         ? 1'b1 : !primary_coded;
      test_low_power <= recovery_mode;
    end
  end

  // Alarms and recovery mode
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      major_alarm <= 1'b0;
      pass_flag <= 1'b0;
    end
    else if (out_fail)
    begin
      major_alarm <= 1'b1;
      pass_flag <= 1'b0;
    end
    else if (out_good)
    begin
      major_alarm <= 1'b0;
      pass_flag <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      recovery_mode <= 1'b0;
      recovered <= 1'b0;
      pass_cnt <= 2'h0;
    end
    else if (out_fail && is_master && recovery_en)
    begin
      recovery_mode <= 1'b1;
      recovered <= 1'b0;
      pass_cnt <= 2'h0;
    end
    else if (out_good && recovery_mode)
    begin
      if (pass_cnt + 2'h1 == RECOVERY_PASSES)
      begin
        recovery_mode <= 1'b0;
        recovered <= 1'b1;
        pass_cnt <= 2'h0;
      end
      else
        pass_cnt <= pass_cnt + 2'h1;
    end
  end

  // Recovery indication
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      blink <= 1'b0;
      rcv_hold <= 3'h0;
      recovery_led <= 1'b0;
    end
    else
    begin
      if (tick)
        blink <= !blink;
      if (out_good && recovery_mode && pass_cnt + 2'h1 == RECOVERY_PASSES)
        rcv_hold <= RECOVER_OUT_S;
      else if (tick && rcv_hold != 3'h0)
        rcv_hold <= rcv_hold - 3'h1;
      recovery_led <= recovery_mode ? blink : recovered;
    end
  end

  // User outputs
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      user_out <= 3'h0;
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        case (out_sel[i])
          OUT_DELAY: user_out[i] <= delayed_alarm;
          OUT_TESTING: user_out[i] <= state != ST_IDLE;
          OUT_PASS: user_out[i] <= pass_flag;
          OUT_RECOVER: user_out[i] <= rcv_hold != 3'h0;
          OUT_DISABLE: user_out[i] <= !auto_en;
          default: user_out[i] <= 1'b0;
        endcase
      end
    end
  end

endmodule // checkback_test_scheduler

// ===== verification/checkback_engine_model.sv
// Behavioural test engine: answers each test start after a set latency.
// Assumes test_start is a one-cycle pulse while no attempt is open.
`timescale 1ns/1ps

module checkback_engine_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Bench controls
  input wire logic pass_req,
  input wire logic [3:0] lat,
  // Engine handshake
  input wire logic test_start,
  output logic test_done,
  output logic test_pass
);
  logic [3:0] cnt;
  logic busy;

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      busy <= 1'b0;
      cnt <= 4'h0;
      test_done <= 1'b0;
      test_pass <= 1'b0;
    end
    else
    begin
      test_done <= busy && cnt == 4'h0;
      // Verdict only meaningful with done
      test_pass <= (busy && cnt == 4'h0) ? pass_req : ~test_pass;
      if (test_start)
      begin
        busy <= 1'b1;
        cnt <= lat;
      end
      else if (busy)
      begin
        busy <= cnt != 4'h0;
        cnt <= cnt - 4'h1;
      end
    end
endmodule // checkback_engine_model

// ===== verification/checkback_sched_sva.sv
// Assertions tying scheduler outputs to their causes.
// Assumes a bind to checkback_test_scheduler; one clock domain.
`timescale 1ns/1ps

module checkback_sched_sva
  import checkback_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Test engine
  input wire logic test_start,
  input wire logic test_low_power,
  input wire logic test_done,
  input wire logic test_pass,
  // Alarms and sync
  input wire logic major_alarm,
  input wire logic delayed_alarm,
  input wire logic sync_push,
  input wire tod_t sync_time_out
);
  logic [3:0] fail_hist;
  logic [3:0] pass_hist;

  // Recent attempt verdicts
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      fail_hist <= 4'h0;
      pass_hist <= 4'h0;
    end
    else
    begin
      fail_hist <= {fail_hist[2:0], test_done & ~test_pass};
      pass_hist <= {pass_hist[2:0], test_done & test_pass};
    end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  start_pulse_a: assert property (test_start |=> !test_start)
    else $error("test start wider than one cycle");
  enter_recovery_a: assert property ($rose(test_low_power) |-> |fail_hist)
    else $error("recovery entered without a failed test");
  leave_recovery_a: assert property ($fell(test_low_power) |-> |pass_hist)
    else $error("recovery left without a good test");
  major_cause_a: assert property ($rose(major_alarm) |-> |fail_hist)
    else $error("major alarm without a failed test");
  pass_clears_a: assert property (test_done && test_pass |-> ##[1:3] !major_alarm)
    else $error("major alarm kept after a good test");
  delayed_cause_a: assert property ($rose(delayed_alarm) |-> test_low_power)
    else $error("delayed alarm outside recovery");
  sync_time_a: assert property (sync_push |->
    sync_time_out.hour == 5'h00 && sync_time_out.minute == 6'h1e)
    else $error("sync pushed away from half past midnight");
  sync_pulse_a: assert property (sync_push |=> !sync_push)
    else $error("sync push wider than one cycle");

  cover property ($rose(test_low_power));
  cover property ($rose(delayed_alarm));
  cover property (sync_push);
endmodule // checkback_sched_sva

// ===== verification/checkback_test_scheduler_test.sv
// Testbench: APB setup, test sources, retries, recovery, schedules, sync.
// Assumes the behavioural engine model and a shortened one-second tick.
`timescale 1ns/1ps

module checkback_test_scheduler_test;
  import checkback_pkg::*;
  localparam int TK = 2;
  localparam logic [31:0] PW [4] = '{32'h00190a79, 32'h00180501, 32'h00000578, 32'h00010701};
  localparam logic [31:0] PE [4] = '{32'h00050a08, 32'h00180501, 32'h00180578, 32'h00010701};
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic test_pushbutton = 1'b0;
  logic rear_test_contact = 1'b0;
  logic config_custom = 1'b0;
  logic message_busy = 1'b0;
  logic peer_test_good = 1'b0;
  logic pass_req = 1'b1;
  logic [3:0] lat = 4'h2;
  logic [31:0] prdata;
  logic pready, pslverr, test_start, test_low_power, test_timed_mode, test_done, test_pass;
  logic sync_push, recovery_led, major_alarm, delayed_alarm, last_timed, last_lp;
  logic [2:0] user_out;
  tod_t sync_time_out;
  logic [15:0] lfsr = 16'h58dc;
  logic [31:0] nstart = 32'h0;
  logic [31:0] ctrl = 32'h0;
  int mismatches = 0;
  int samples_checked = 0;

  always #10 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
    if (test_start === 1'b1)
    begin
      nstart <= nstart + 32'h1;
      last_timed <= test_timed_mode;
      last_lp <= test_low_power;
    end

  checkback_test_scheduler #(.TICK_COUNT(TK)) checkback_test_scheduler_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .test_pushbutton(test_pushbutton), .rear_test_contact(rear_test_contact),
    .config_custom(config_custom), .test_start(test_start), .test_low_power(test_low_power),
    .test_timed_mode(test_timed_mode), .test_done(test_done), .test_pass(test_pass),
    .message_busy(message_busy), .peer_test_good(peer_test_good), .sync_load(1'b0),
    .sync_time_in(17'h0),
    .sync_push(sync_push), .sync_time_out(sync_time_out), .recovery_led(recovery_led),
    .major_alarm(major_alarm), .delayed_alarm(delayed_alarm), .user_out(user_out));

  checkback_engine_model checkback_engine_model_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .pass_req(pass_req), .lat(lat), .test_start(test_start), .test_done(test_done),
    .test_pass(test_pass));

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    if (!ex)
      chk("read data", r, x);
    chk("slave error", {31'h0, e}, {31'h0, ex});
  endtask

  // Source 0 pushbutton, 1 rear contact, 2 manual command
  task automatic trig(input int s);
    lfsr = lfsr_next(lfsr);
    lat <= lfsr[3:0];
    if (s < 2)
    begin
      @(posedge ref_clk);
      test_pushbutton <= s == 0;
      rear_test_contact <= s == 1;
      repeat (3) @(posedge ref_clk);
      test_pushbutton <= 1'b0;
      rear_test_contact <= 1'b0;
    end
    else
      wr(OFS_CTRL, ctrl | 32'h100);
  endtask

  task automatic wait_done(input int k);
    for (int n = 0; n < 400 && k > 0; n++)
    begin
      @(posedge ref_clk);
      k -= (test_done === 1'b1);
    end
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    logic [31:0] n0;
    logic [31:0] d;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdc(OFS_PERIOD, 32'h00010f08, 1'b0);
    rdc(OFS_SETUP, 32'h00000300, 1'b0);
    rdc(8'h1c, 32'h0, 1'b1);
    rdc(8'h02, 32'h0, 1'b1);
    wr(OFS_PERIOD, 32'h00050501);
    rdc(OFS_PERIOD, 32'h00050508, 1'b0);
    config_custom <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_PERIOD, PW[i]);
      rdc(OFS_PERIOD, PE[i], 1'b0);
    end
    repeat (4)
    begin
      lfsr = lfsr_next(lfsr);
      d = {lfsr, lfsr};
      wr(OFS_DATE, d);
      rdc(OFS_DATE, d & 32'hffff0f1f, 1'b0);
    end
    for (int s = 0; s < 3; s++)
    begin
      n0 = nstart;
      trig(s);
      wait_done(1);
      chk("starts", nstart - n0, 32'h1);
    end
    wr(OFS_SETUP, 32'h00000100);
    pass_req <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      ctrl = (i == 0) ? 32'h30 : (i == 1) ? 32'h10 : 32'h20;
      n0 = nstart;
      trig(2);
      wait_done(3);
      chk("attempts", nstart - n0, (i == 0) ? 32'h3 : 32'h2);
      chk("timed mode", {31'h0, last_timed}, {31'h0, i != 1});
      chk("major", {31'h0, major_alarm}, 32'h1);
    end
    pass_req <= 1'b1;
    ctrl = 32'h0;
    trig(2);
    wait_done(1);
    chk("major", {31'h0, major_alarm}, 32'h0);
    wr(OFS_SETUP, 32'h0);
    ctrl = 32'h4;
    pass_req <= 1'b0;
    trig(2);
    wait_done(1);
    chk("low power", {31'h0, test_low_power}, 32'h1);
    n0 = nstart;
    // Seven minute period keeps retests clear of the window end
    repeat (420 * TK + 30) @(posedge ref_clk);
    chk("retest", nstart - n0, 32'h1);
    chk("retest power", {31'h0, last_lp}, 32'h1);
    for (int i = 0; i < 8000 && delayed_alarm !== 1'b1; i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    chk("delayed", {31'h0, delayed_alarm}, 32'h1);
    chk("outputs", {29'h0, user_out}, 32'h7);
    pass_req <= 1'b1;
    repeat (3)
    begin
      trig(2);
      wait_done(1);
    end
    chk("recovered", {31'h0, test_low_power}, 32'h0);
    chk("led", {31'h0, recovery_led}, 32'h1);
    ctrl = 32'h3;
    wr(OFS_CTRL, ctrl);
    n0 = nstart;
    repeat (3600 * TK - 60) @(posedge ref_clk);
    chk("early", nstart - n0, 32'h0);
    peer_test_good <= 1'b1;
    @(posedge ref_clk);
    peer_test_good <= 1'b0;
    repeat (3600 * TK - 60) @(posedge ref_clk);
    chk("peer restart", nstart - n0, 32'h0);
    repeat (120) @(posedge ref_clk);
    chk("periodic", nstart - n0, 32'h1);
    ctrl = 32'h8;
    wr(OFS_CTRL, ctrl);
    wr(OFS_TOD, 32'h00001d3a);
    for (int i = 0; i < 40 && sync_push !== 1'b1; i++) @(posedge ref_clk);
    chk("sync", {31'h0, sync_push}, 32'h1);
    ctrl = 32'h1;
    wr(OFS_CTRL, ctrl);
    wr(OFS_TIMES, 32'h01010101);
    message_busy <= 1'b1;
    wr(OFS_TOD, 32'h0001043a);
    n0 = nstart;
    repeat (10 * TK + 20) @(posedge ref_clk);
    chk("busy", nstart - n0, 32'h0);
    message_busy <= 1'b0;
    wr(OFS_TOD, 32'h0001043a);
    repeat (10 * TK + 20) @(posedge ref_clk);
    chk("timed", nstart - n0, 32'h1);
    print_verdict();
  end

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end
endmodule // checkback_test_scheduler_test

bind checkback_test_scheduler checkback_sched_sva #(.TICK_COUNT(TICK_COUNT)) checkback_sched_sva_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .test_start(test_start),
  .test_low_power(test_low_power), .test_done(test_done), .test_pass(test_pass),
  .major_alarm(major_alarm), .delayed_alarm(delayed_alarm), .sync_push(sync_push),
  .sync_time_out(sync_time_out));
